// File: sswc_top.v
/*
 Supply supervisor and wakeup control: control registers, per-mode unit
 states, wakeup hold-off, settle flags, overshoot and hang indications.
 Assumes synchronous inputs and a master that never waits.
*/
`timescale 1ns/1ps
`include "sswc_consts.vh"
module sswc_top #(
	parameter SLOW_CYC = `SSWC_SLOW_CYC
) (
	input wire clock, // System clock, 200 MHz.
	input wire arst_n, // Asynchronous reset, active low.
	input wire power_up_clear, // Power-up clear pulse, resets controls.
	input wire [3:0] addr, // Register index.
	input wire [15:0] wdata, // Write data.
	input wire wr_en, // Write strobe.
	input wire rd_en, // Read strobe.
	output reg [15:0] rdata, // Read data, one cycle after strobe.
	input wire deep_sleep, // Level: device is in a clock-stopped mode.
	input wire wake_irq, // Wakeup interrupt pulse.
	output wire cpu_hold, // CPU execution held off.
	output wire mclk_overshoot, // Main clock exposed to overshoot.
	output wire sub_clk_overshoot, // Sub clock overshooting, unmasked.
	output reg wakeup_hang, // Wakeup lost, cleared by reset or clear.
	output wire hang_config, // Configuration prone to wakeup hang.
	output wire [7:0] unit_state // Two-bit states, core sup first.
);
	localparam integer FAST_INT = `SSWC_FAST_CYC;
	localparam integer OVS_INT = `SSWC_OVERSHOOT_CYC;
	localparam integer HANG_INT = `SSWC_HANG_CYC;
	localparam [16:0] FAST_CYC = FAST_INT[16:0];
	localparam [16:0] OVS_CYC = OVS_INT[16:0];
	localparam [16:0] HANG_CYC = HANG_INT[16:0];
	localparam [2:0] S_RUN = 3'b001;
	localparam [2:0] S_SLEEP = 3'b010;
	localparam [2:0] S_WAKE = 3'b100;
	reg [5:0] core_ctl_q;
	reg [5:0] ext_ctl_q;
	reg [1:0] core_level_q;
	reg mclk_from_osc_q;
	reg sub_from_osc_q;
	reg [4:0] osc_mhz_q;
	reg [2:0] state_q;
	reg [16:0] hold_cnt_q;
	reg [16:0] ovs_cnt_q;
	reg [16:0] entry_cnt_q;
	reg [16:0] core_set_q;
	reg [16:0] ext_set_q;
	reg core_settle_delay_flag_q;
	reg ext_settle_delay_flag_q;
	wire core_wr = wr_en && addr == `SSWC_ADR_CORE_CTL;
	wire ext_wr = wr_en && addr == `SSWC_ADR_EXT_CTL;

	////////////////////////////////////////////////////////////////////////
	// Unit states in the current power mode.
	function [1:0] sup_state;
		input en;
		input keep;
		input fp;
		input auto;
		input deep;
		begin
			if (!en) begin
				sup_state = `SSWC_ST_OFF;
			end else if (!deep) begin
				sup_state = fp ? `SSWC_ST_FULL : `SSWC_ST_NORM;
			end else if (!keep) begin
				sup_state = `SSWC_ST_OFF;
			end else if (auto) begin
				sup_state = fp ? `SSWC_ST_NORM : `SSWC_ST_OFF;
			end else begin
				sup_state = fp ? `SSWC_ST_FULL : `SSWC_ST_NORM;
			end
		end
	endfunction

	function [1:0] mon_state;
		input en;
		input fp;
		input auto;
		input deep;
		begin
			if (!en) begin
				mon_state = `SSWC_ST_OFF;
			end else if (deep && auto) begin
				mon_state = fp ? `SSWC_ST_NORM : `SSWC_ST_OFF;
			end else begin
				mon_state = fp ? `SSWC_ST_FULL : `SSWC_ST_NORM;
			end
		end
	endfunction

	wire deep = state_q == S_SLEEP;
	wire [1:0] cs_st = sup_state(core_ctl_q[`SSWC_B_SUP_EN],
		core_ctl_q[`SSWC_B_SUP_KEEP], core_ctl_q[`SSWC_B_SUP_FP],
		core_ctl_q[`SSWC_B_AUTO], deep);
	wire [1:0] cm_st = mon_state(core_ctl_q[`SSWC_B_MON_EN],
		core_ctl_q[`SSWC_B_MON_FP], core_ctl_q[`SSWC_B_AUTO], deep);
	wire [1:0] es_st = sup_state(ext_ctl_q[`SSWC_B_SUP_EN],
		ext_ctl_q[`SSWC_B_SUP_KEEP], ext_ctl_q[`SSWC_B_SUP_FP],
		ext_ctl_q[`SSWC_B_AUTO], deep);
	wire [1:0] em_st = mon_state(ext_ctl_q[`SSWC_B_MON_EN],
		ext_ctl_q[`SSWC_B_MON_FP], ext_ctl_q[`SSWC_B_AUTO], deep);
	assign unit_state = {em_st, es_st, cm_st, cs_st};

	// Slow wakeup only when a core unit sits in normal mode while active.
	wire core_sup_slow = core_ctl_q[`SSWC_B_SUP_EN] &&
		!core_ctl_q[`SSWC_B_SUP_FP];
	wire core_mon_slow = core_ctl_q[`SSWC_B_MON_EN] &&
		!core_ctl_q[`SSWC_B_MON_FP];
	wire slow_wake = core_sup_slow || core_mon_slow;
	wire [16:0] slow_len = SLOW_CYC[16:0];

	// External unit leaving normal for off on entry to deep sleep.
	wire es_n2o = ext_ctl_q[`SSWC_B_SUP_EN] && !ext_ctl_q[`SSWC_B_SUP_FP] &&
		(!ext_ctl_q[`SSWC_B_SUP_KEEP] || ext_ctl_q[`SSWC_B_AUTO]);
	wire em_n2o = ext_ctl_q[`SSWC_B_MON_EN] && !ext_ctl_q[`SSWC_B_MON_FP] &&
		ext_ctl_q[`SSWC_B_AUTO];
	assign hang_config = (!core_sup_slow || !core_mon_slow) &&
		(es_n2o || em_n2o);

	////////////////////////////////////////////////////////////////////////
	// Overshoot exposure limit per core level.
	reg [4:0] lim;
	always @* begin
		case (core_level_q)
		2'h0: lim = `SSWC_LIM0;
		2'h1: lim = `SSWC_LIM1;
		2'h2: lim = `SSWC_LIM2;
		default: lim = `SSWC_LIM3;
		endcase
	end
	wire ovs_active = ovs_cnt_q != 17'h00000;
	assign mclk_overshoot = ovs_active && !cpu_hold && mclk_from_osc_q &&
		osc_mhz_q > lim;
	assign sub_clk_overshoot = ovs_active && sub_from_osc_q;
	assign cpu_hold = state_q == S_WAKE;

	////////////////////////////////////////////////////////////////////////
	// Power mode sequencing and counters.
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_RUN;
			hold_cnt_q <= 17'h00000;
			ovs_cnt_q <= 17'h00000;
			entry_cnt_q <= 17'h00000;
			wakeup_hang <= 1'b0;
		end else if (power_up_clear) begin
			state_q <= S_RUN;
			hold_cnt_q <= 17'h00000;
			ovs_cnt_q <= 17'h00000;
			entry_cnt_q <= 17'h00000;
			wakeup_hang <= 1'b0;
		end else begin
			if (ovs_active) begin
				ovs_cnt_q <= ovs_cnt_q - 17'h00001;
			end
			if (entry_cnt_q != 17'h00000) begin
				entry_cnt_q <= entry_cnt_q - 17'h00001;
			end
			case (state_q)
			S_RUN: begin
				if (deep_sleep) begin
					state_q <= S_SLEEP;
					entry_cnt_q <= HANG_CYC;
				end
			end
			S_SLEEP: begin
				if (wakeup_hang) begin
					state_q <= S_SLEEP;
				end else if (wake_irq && entry_cnt_q != 17'h00000 &&
					(hang_config || core_settle_delay_flag_q ||
					ext_settle_delay_flag_q)) begin
					wakeup_hang <= 1'b1;
				end else if (wake_irq) begin
					state_q <= S_WAKE;
					ovs_cnt_q <= OVS_CYC;
					hold_cnt_q <= slow_wake ? slow_len : FAST_CYC;
				end
			end
			S_WAKE: begin
				if (hold_cnt_q <= 17'h00001) begin
					state_q <= S_RUN;
					hold_cnt_q <= 17'h00000;
				end else begin
					hold_cnt_q <= hold_cnt_q - 17'h00001;
				end
			end
			default: state_q <= S_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers and settle flags.
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			core_ctl_q <= `SSWC_CORE_RST;
			ext_ctl_q <= `SSWC_EXT_RST;
			core_level_q <= 2'h0;
			mclk_from_osc_q <= 1'b1;
			sub_from_osc_q <= 1'b1;
			osc_mhz_q <= 5'h01;
			core_set_q <= 17'h00000;
			ext_set_q <= 17'h00000;
			core_settle_delay_flag_q <= 1'b0;
			ext_settle_delay_flag_q <= 1'b0;
		end else if (power_up_clear) begin
			core_ctl_q <= `SSWC_CORE_RST;
			ext_ctl_q <= `SSWC_EXT_RST;
			core_set_q <= 17'h00000;
			ext_set_q <= 17'h00000;
			core_settle_delay_flag_q <= 1'b0;
			ext_settle_delay_flag_q <= 1'b0;
		end else begin
			// Settle length follows the new performance bit of the supervisor.
			if (core_wr) begin
				core_ctl_q <= wdata[5:0];
				core_settle_delay_flag_q <= 1'b1;
				core_set_q <= wdata[`SSWC_B_SUP_FP] ? FAST_CYC : slow_len;
			end else if (core_set_q > 17'h00001) begin
				core_set_q <= core_set_q - 17'h00001;
			end else begin
				core_set_q <= 17'h00000;
				core_settle_delay_flag_q <= 1'b0;
			end
			if (ext_wr) begin
				ext_ctl_q <= wdata[5:0];
				ext_settle_delay_flag_q <= 1'b1;
				ext_set_q <= wdata[`SSWC_B_SUP_FP] ? FAST_CYC : slow_len;
			end else if (ext_set_q > 17'h00001) begin
				ext_set_q <= ext_set_q - 17'h00001;
			end else begin
				ext_set_q <= 17'h00000;
				ext_settle_delay_flag_q <= 1'b0;
			end
			if (wr_en && addr == `SSWC_ADR_CLKCFG) begin
				core_level_q <= wdata[1:0];
				mclk_from_osc_q <= wdata[2];
				sub_from_osc_q <= wdata[3];
				osc_mhz_q <= wdata[8:4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data stands only in the cycle after the strobe.
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 16'h0000;
		end else if (rd_en) begin
			case (addr)
			`SSWC_ADR_CORE_CTL: rdata <= {10'h000, core_ctl_q};
			`SSWC_ADR_EXT_CTL: rdata <= {10'h000, ext_ctl_q};
			`SSWC_ADR_FLAGS: rdata <= {14'h0000, ext_settle_delay_flag_q,
				core_settle_delay_flag_q};
			`SSWC_ADR_CLKCFG: rdata <= {7'h00, osc_mhz_q, sub_from_osc_q,
				mclk_from_osc_q, core_level_q};
			`SSWC_ADR_STATE: rdata <= {5'h00, wakeup_hang, hang_config,
				cpu_hold, unit_state};
			default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule // sswc_top

// File: sswc_consts.vh
/*
 Constants for the supply supervisor and wakeup control block.
 Assumes a 200 MHz system clock and a plain register port.
*/
// Contract
// - Oscillator may overshoot for up to 6 us after deepest-mode exit.
// - Core units enabled in normal mode hold the CPU 150 us on wakeup.
// - Core units off or full performance shorten hold-off to 2 us.
// - Overshoot matters only above 4/7/11/14 MHz for core levels 0-3.
// - Sub clock gets no wakeup masking; its peripherals see the overshoot.
// - Full-performance settle is 2 us; raising core level then resets device. Here a core level write during settle just takes effect, with no reset.
// - Interrupt within 1 us of affected stop-mode entry may fail to wake.
// - Core supervisor state mapping per enable, keep, fullperf, auto bits.
// - Core monitor state mapping; auto turns normal off, full to normal.
// - External supervisor and monitor follow the same mapping.
// - Hang risk when core is fast-wake or off and external normal goes off; hang_config flags it when either core unit is fast or off.
`ifndef SSWC_CONSTS_VH
`define SSWC_CONSTS_VH
`define SSWC_CLK_MHZ 200
`define SSWC_OVERSHOOT_NS 6000
`define SSWC_SLOW_NS 150000
`define SSWC_FAST_NS 2000
`define SSWC_HANG_NS 1000
`define SSWC_OVERSHOOT_CYC (`SSWC_OVERSHOOT_NS * `SSWC_CLK_MHZ / 1000)
`define SSWC_SLOW_CYC (`SSWC_SLOW_NS * `SSWC_CLK_MHZ / 1000)
`define SSWC_FAST_CYC (`SSWC_FAST_NS * `SSWC_CLK_MHZ / 1000)
`define SSWC_HANG_CYC (`SSWC_HANG_NS * `SSWC_CLK_MHZ / 1000)
`define SSWC_ADR_CORE_CTL 4'h0
`define SSWC_ADR_EXT_CTL 4'h1
`define SSWC_ADR_FLAGS 4'h2
`define SSWC_ADR_CLKCFG 4'h3
`define SSWC_ADR_STATE 4'h4
`define SSWC_B_SUP_EN 0
`define SSWC_B_SUP_KEEP 1
`define SSWC_B_SUP_FP 2
`define SSWC_B_MON_EN 3
`define SSWC_B_MON_FP 4
`define SSWC_B_AUTO 5
`define SSWC_CORE_RST 6'h01
`define SSWC_EXT_RST 6'h01
`define SSWC_ST_OFF 2'h0
`define SSWC_ST_NORM 2'h1
`define SSWC_ST_FULL 2'h2
`define SSWC_LIM0 5'h04
`define SSWC_LIM1 5'h07
`define SSWC_LIM2 5'h0b
`define SSWC_LIM3 5'h0e
`endif

// File: sswc_properties.sv
/* Assertions on the ports of sswc_top.
 Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`include "sswc_consts.vh"
module sswc_properties #(
	parameter SLOW_CYC = 30000
) (
	input wire clock, // Clock.
	input wire arst_n, // Reset.
	input wire power_up_clear, // Clear.
	input wire [3:0] addr, // Index.
	input wire wr_en, // Write.
	input wire rd_en, // Read.
	input wire [15:0] rdata, // Data.
	input wire wake_irq, // Wake.
	input wire cpu_hold, // Hold.
	input wire mclk_overshoot, // Fast.
	input wire wakeup_hang // Hang.
);
	localparam int HLIM = (SLOW_CYC > 400) ? SLOW_CYC : 400;
	reg [15:0] hold_cnt_q;
	reg [15:0] ovs_run_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// A hold that never ends would freeze the CPU, so its run is bounded.
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hold_cnt_q <= 16'h0;
			ovs_run_q <= 16'h0;
		end else begin
			hold_cnt_q <= cpu_hold ? hold_cnt_q + 16'h1 : 16'h0;
			ovs_run_q <= mclk_overshoot ? ovs_run_q + 16'h1 : 16'h0;
		end
	end
	hold_bound_a: assert property (hold_cnt_q <= HLIM)
		else $error("hold too long");
	hold_cause_a: assert property ($rose(cpu_hold) |-> $past(wake_irq))
		else $error("hold without wake");
	hold_min_a: assert property ($rose(cpu_hold) |-> cpu_hold[*8])
		else $error("hold too short");
	over_held_a: assert property (mclk_overshoot |-> !cpu_hold)
		else $error("overshoot while held");
	ovs_bound_a: assert property (ovs_run_q <= `SSWC_OVERSHOOT_CYC)
		else $error("overshoot too long");
	flag_set_a: assert property (wr_en && addr == `SSWC_ADR_CORE_CTL ##1
		rd_en && addr == `SSWC_ADR_FLAGS |=> rdata[0]) else $error("no flag");
	flag_ro_a: assert property ($past(rd_en) &&
		$past(addr) == `SSWC_ADR_FLAGS |-> rdata[15:2] == 14'h0)
		else $error("flag spare bits");
	hang_hold_a: assert property (wakeup_hang && !power_up_clear |=> wakeup_hang)
		else $error("hang lost");
	hang_cause_a: assert property ($rose(wakeup_hang) |-> $past(wake_irq))
		else $error("hang without wake");
	hang_clear_a: assert property (power_up_clear |=> !wakeup_hang)
		else $error("hang kept");
	cover property ($rose(cpu_hold));
	cover property ($rose(wakeup_hang));
	cover property ($rose(mclk_overshoot));
endmodule // sswc_properties
bind sswc_top sswc_properties #(.SLOW_CYC(SLOW_CYC)) i_sswc_properties (
	.clock(clock), .arst_n(arst_n), .power_up_clear(power_up_clear), .addr(addr), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .wake_irq(wake_irq), .cpu_hold(cpu_hold),
	.mclk_overshoot(mclk_overshoot), .wakeup_hang(wakeup_hang));

// File: tb_top.sv
/* Self-checking bench for sswc_top.
 Assumes the checker is bound in and SLOW_CYC is cut to 50. */
`timescale 1ns/1ps
`include "sswc_consts.vh"
module tb_top;
	localparam int SLOW = 50;
	reg clock = 1'b0, arst_n = 1'b0, power_up_clear = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	reg deep_sleep = 1'b0, wake_irq = 1'b0, rd_seen = 1'b0;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0;
	wire [15:0] rdata;
	wire [7:0] unit_state;
	wire cpu_hold, mclk_overshoot, sub_clk_overshoot, wakeup_hang, hang_config;
	logic [15:0] exp_q[$];
	logic [5:0] c, e;
	int seed = 32'h2fba3a89;
	int bad_count = 0, n_compared = 0, cycles = 0, n;
	sswc_top #(.SLOW_CYC(SLOW)) i_sswc_top (.clock(clock), .arst_n(arst_n),
		.power_up_clear(power_up_clear), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .deep_sleep(deep_sleep), .wake_irq(wake_irq),
		.cpu_hold(cpu_hold), .mclk_overshoot(mclk_overshoot),
		.sub_clk_overshoot(sub_clk_overshoot), .wakeup_hang(wakeup_hang),
		.hang_config(hang_config), .unit_state(unit_state));
	initial begin
		forever #2.5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Reads queue their expectation; the result lands one cycle later.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		rd_seen <= rd_en;
		if (rd_seen === 1'b1)
			chk(rdata, exp_q.pop_front());
		if (cycles == 60000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic op(input logic w, r, input logic [3:0] a, input logic [15:0] d);
		wr_en <= w;
		rd_en <= r;
		addr <= a;
		wdata <= d;
		@(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		op(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		exp_q.push_back(x);
		op(1'b0, 1'b1, a, 16'h0);
	endtask
	task automatic cyc(input int k);
		op(1'b0, 1'b0, 4'h0, 16'h0);
		repeat (k - 1) @(posedge clock);
	endtask
	task automatic rst();
		arst_n <= 1'b0;
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
	endtask
	task automatic wake();
		wake_irq <= 1'b1;
		deep_sleep <= 1'b0;
		@(posedge clock);
		wake_irq <= 1'b0;
	endtask
	function automatic logic [1:0] st(input logic [5:0] x, input bit m, dp);
		logic en, fp;
		en = m ? x[3] : x[0];
		fp = m ? x[4] : x[2];
		if (!en || (dp && !m && !x[1]))
			return 2'h0;
		if (dp && x[5])
			return fp ? 2'h1 : 2'h0;
		return fp ? 2'h2 : 2'h1;
	endfunction
	function automatic logic [7:0] us(input bit dp);
		return {st(e, 1, dp), st(e, 0, dp), st(c, 1, dp), st(c, 0, dp)};
	endfunction
	function automatic bit slw(input logic [5:0] x);
		return (x[0] & !x[2]) | (x[3] & !x[4]);
	endfunction
	function automatic bit hcf();
		return (!c[0] | c[2] | !c[3] | c[4]) &
			((e[0] & !e[2] & (!e[1] | e[5])) | (e[3] & !e[4] & e[5]));
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst();
		// Reset controls leave the core monitor off and the external
		// supervisor dropping to off in sleep, so the hang risk shows.
		rd(`SSWC_ADR_STATE, 16'h0211);
		rd(`SSWC_ADR_CORE_CTL, 16'h0001);
		rd(`SSWC_ADR_CLKCFG, 16'h001c);
		wr(`SSWC_ADR_FLAGS, 16'hffff);
		wr(4'hf, 16'hffff);
		rd(`SSWC_ADR_FLAGS, 16'h0000);
		rd(4'hf, 16'h0000);
		wr(`SSWC_ADR_CLKCFG, 16'h00ff);
		$display("registers done");
		for (int i = 0; i < 12; i++) begin
			c = $random(seed);
			e = $random(seed);
			wr(`SSWC_ADR_EXT_CTL, {10'h0, e});
			wr(`SSWC_ADR_CORE_CTL, {10'h0, c});
			rd(`SSWC_ADR_FLAGS, 16'h0003);
			cyc(410);
			rd(`SSWC_ADR_FLAGS, 16'h0000);
			rd(`SSWC_ADR_STATE, {6'h0, hcf(), 1'b0, us(0)});
			cyc(2);
			deep_sleep <= 1'b1;
			cyc(210);
			chk({8'h0, unit_state}, {8'h0, us(1)});
			wake();
			n = 0;
			@(posedge clock);
			while (cpu_hold === 1'b1 && n < 500) begin
				n++;
				@(posedge clock);
			end
			chk(16'(n), slw(c) ? 16'(SLOW) : 16'h190);
			chk({15'h0, sub_clk_overshoot}, 16'h1);
			if (!slw(c))
				chk({15'h0, mclk_overshoot}, 16'h1);
		end
		$display("modes done");
		// Core level kept at 3 in normal mode; the sub clock runs from the
		// second crystal and the oscillator stays under its level limit.
		wr(`SSWC_ADR_CORE_CTL, 16'h0001);
		wr(`SSWC_ADR_CLKCFG, 16'h00c7);
		rd(`SSWC_ADR_CLKCFG, 16'h00c7);
		cyc(60);
		deep_sleep <= 1'b1;
		cyc(210);
		wake();
		cyc(60);
		chk({15'h0, mclk_overshoot}, 16'h0);
		chk({15'h0, sub_clk_overshoot}, 16'h0);
		$display("clocks done");
		// Case 0 hangs on configuration, case 1 on a pending settle flag;
		// cases 2 and 3 are the safe settings and wake inside the window.
		for (int k = 0; k < 4; k++) begin
			c = (k == 2) ? 6'h09 : {5'h00, k == 1};
			e = k[0] ? 6'h03 : 6'h01;
			wr(`SSWC_ADR_EXT_CTL, {10'h0, e});
			wr(`SSWC_ADR_CORE_CTL, {10'h0, c});
			cyc((k == 1) ? 1 : 410);
			deep_sleep <= 1'b1;
			cyc(5);
			wake();
			cyc((k < 2) ? 2 : 410);
			chk({15'h0, wakeup_hang}, {15'h0, k < 2});
			power_up_clear <= 1'b1;
			@(posedge clock);
			power_up_clear <= 1'b0;
			cyc(2);
			chk({15'h0, wakeup_hang}, 16'h0);
			rst();
		end
		rd(`SSWC_ADR_STATE, 16'h0211);
		cyc(2);
		$display("hang done");
		tally_and_finish();
	end
endmodule // tb_top
